// ==== inc/ccdreg_cfg.svh ====
// register numbers, field positions, reset values and timing of the camera register bank
`ifndef CCDREG_CFG_SVH
`define CCDREG_CFG_SVH

// ====================================================================
// register numbers (host select code)
`define CCDREG_R_CMD        4'h1
`define CCDREG_R_TIMER      4'h2
`define CCDREG_R_VBIN       4'h3
`define CCDREG_R_AIC        4'h4
`define CCDREG_R_SETPOINT   4'h5
`define CCDREG_R_PIXCNT     4'h6
`define CCDREG_R_LINECNT    4'h7
`define CCDREG_R_BIC        4'h8
`define CCDREG_R_PIXDATA    4'h9
`define CCDREG_R_TEMP       4'hA
`define CCDREG_R_STATUS     4'hB
`define CCDREG_R_MIRROR     4'hC
`define CCDREG_NUM_WR       8

// ====================================================================
// command bit positions
`define CCDREG_CB_TDI       0
`define CCDREG_CB_STARTTMR  1
`define CCDREG_CB_SHUTOVR   2
`define CCDREG_CB_SYSRST    3
`define CCDREG_CB_FIFOCACHE 4
`define CCDREG_CB_TRIGEN    5
`define CCDREG_CB_STOPFLUSH 6
`define CCDREG_CB_SHUTEN    7
`define CCDREG_CB_COOLDOWN  8
`define CCDREG_CB_DONEREAD  9
`define CCDREG_CB_TMRLOAD   10
`define CCDREG_CB_NEXTLINE  11
`define CCDREG_CB_STARTFL   12
`define CCDREG_CB_COOLEN    15

// ====================================================================
// status bit positions
`define CCDREG_SB_LINERDY   0
`define CCDREG_SB_EXPOSING  1
`define CCDREG_SB_FLUSHING  2
`define CCDREG_SB_DATAAVL   3
`define CCDREG_SB_MINLIM    4
`define CCDREG_SB_MAXLIM    5
`define CCDREG_SB_RAMPDONE  6
`define CCDREG_SB_ATTEMP    7

// ====================================================================
// reset values and constants
`define CCDREG_REG_RST      16'h0000
`define CCDREG_TEMP_BAND    12'h004
`define CCDREG_LEVEL_MAX    8'hFF
`define CCDREG_FIFO_W       16
`define CCDREG_FIFO_D       32

// ====================================================================
// timing: clock period, timer step 10 ms, temperature refresh 8 per second
`define CCDREG_CLK_NS       8
`define CCDREG_TMR_STEP_NS  10000000
`define CCDREG_TEMP_UPD_NS  125000000

`endif

// ==== inc/ccdreg_pkg.sv ====
// types shared by the camera register bank
`default_nettype none
package ccdreg_pkg;

	// ====================================================================
	// sequencer states, gray along expose-skip-rows-cols-hold
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_FLUSH  = 3'h1,
		ST_EXPOSE = 3'h3,
		ST_SKIP   = 3'h2,
		ST_ROWS   = 3'h6,
		ST_COLS   = 3'h7,
		ST_HOLD   = 3'h5
	} ccdreg_state_t;

	typedef enum logic [1:0] {
		COL_BEFORE = 2'h0,
		COL_PIXEL  = 2'h1,
		COL_AFTER  = 2'h3
	} ccdreg_colph_t;

	// ====================================================================
	// geometry fields decoded from the writable registers
	typedef struct packed {
		logic [7:0]  vBin;
		logic [3:0]  hBin;
		logic [11:0] pixCount;
		logic [11:0] lineCount;
		logic [11:0] beforeCols;
		logic [11:0] afterCols;
	} ccdreg_geom_t;

	// ====================================================================
	// sensor drive pins
	typedef struct packed {
		logic vClk;
		logic hClk;
		logic shutter;
	} ccdreg_drive_t;

endpackage
`default_nettype wire

// ==== src/ccdreg_fifo.sv ====
// pixel fifo between the digitiser and the image data register
`timescale 1ns/10ps
`default_nettype none
module ccdreg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// ====================================================================
	// handshake
	assign inReady  = (count_r != DEPTH[AW:0]);
	assign outValid = (count_r != '0);
	assign outData  = mem_r[rdPtr_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// ====================================================================
	// storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	// ====================================================================
	// pointers; depth is a power of two so pointers wrap freely
	always_ff @(posedge ref_clk) begin
		if (!rstn || flush) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== src/ccdreg_top.sv ====
// camera controller register bank with exposure, readout and cooler logic
`timescale 1ns/10ps
`default_nettype none
`include "ccdreg_cfg.svh"

// Contract
// - twelve sixteen-bit registers form the whole interface
// - eight writable registers, read back except reg2 and the low bits of reg3, which return the timer
// - four read-only: pixels, temperature, status, mirror
// - reg3 timer high and vbin; reg2 timer low
// - reg6 pixels and hbin; reg7 lines
// - reg4 after columns, reg8 before columns
// - reg5 setpoint and digital port
// - reg12 returns last command bits written
// - no interrupts or dma; host polls lines
// - sequencer runs exposure, counting, flushing, cooling autonomously
// - status bit 7 high on reaching setpoint
// - temperature reading refreshed eight times per second
// - status 4..7 and mirror 8,15 encode cooler
// - line count counts unbinned rows
// - after exposure, skip the row offset automatically
module ccdreg_top #(
	parameter int TMR_STEP_CYC = `CCDREG_TMR_STEP_NS / `CCDREG_CLK_NS,
	parameter int TEMP_UPD_CYC = `CCDREG_TEMP_UPD_NS / `CCDREG_CLK_NS
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	input  wire logic [3:0]            regSel,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	input  wire logic [15:0]           regWrData,
	output logic      [15:0]           regRdData,
	output ccdreg_pkg::ccdreg_drive_t  ccdDrive,
	input  wire logic [15:0]           adcSample,
	input  wire logic                  extTrigger,
	input  wire logic [15:0]           tempSense,
	output logic      [7:0]            coolerDrive,
	output logic      [3:0]            digPort
);
	// ====================================================================
	// declarations
	logic [15:0]               regs_r [`CCDREG_NUM_WR];
	logic [15:0]               cmdPrev_r;
	logic [19:0]               timer_r;
	logic [31:0]               stepCnt_r;
	logic [31:0]               tempCnt_r;
	logic [15:0]               tempS1_r, tempS2_r, tempS3_r, tempF_r, temp_r;
	logic [2:0]                trigS_r;
	logic                      trigF_r, trigPrev_r;
	logic [7:0]                level_r;
	ccdreg_pkg::ccdreg_state_t state_r;
	ccdreg_pkg::ccdreg_colph_t colPh_r;
	ccdreg_pkg::ccdreg_geom_t  geom;
	ccdreg_pkg::ccdreg_drive_t drive_r;
	logic [11:0]               cnt_r;
	logic [3:0]                binCnt_r;
	logic [15:0]               cmd, status;
	logic                      wrOk, softRst, seqRst;
	logic                      tmrStep, tempUpd, trigRise;
	logic                      fifoInReady, fifoOutValid, fifoPop, fifoPush;
	logic [15:0]               fifoOut;
	logic                      atTemp, maxLim, minLim, rampDone;

	// falling edge of a command bit triggers its action
	function automatic logic cmdFell(input logic [15:0] prev, input logic [15:0] cur, input int idx);
		cmdFell = prev[idx] && !cur[idx];
	endfunction

	function automatic logic selIs(input logic [3:0] sel, input logic [3:0] num);
		selIs = (sel == num);
	endfunction

	// ====================================================================
	// writable registers 1..8; 9..12 have no storage
	assign wrOk = regWr && (regSel >= `CCDREG_R_CMD) && (regSel <= `CCDREG_R_BIC);
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			for (int i = 0; i < `CCDREG_NUM_WR; i++) begin
				regs_r[i] <= `CCDREG_REG_RST;
			end
		end else if (wrOk) begin
			regs_r[3'(regSel - 4'h1)] <= regWrData;
		end
	end

	assign cmd = regs_r[0];
	assign digPort = regs_r[4][15:12];
	assign geom.vBin       = regs_r[2][11:4];
	assign geom.afterCols  = regs_r[3][11:0];
	assign geom.pixCount   = regs_r[5][11:0];
	assign geom.hBin       = regs_r[5][15:12];
	assign geom.lineCount  = regs_r[6][11:0];
	assign geom.beforeCols = regs_r[7][11:0];

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmdPrev_r <= `CCDREG_REG_RST;
		end else begin
			cmdPrev_r <= cmd;
		end
	end
	assign softRst = cmdFell(cmdPrev_r, cmd, `CCDREG_CB_SYSRST);
	assign seqRst  = !rstn || softRst;

	// ====================================================================
	// pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tempS1_r <= 16'h0000;
			tempS2_r <= 16'h0000;
			tempS3_r <= 16'h0000;
			tempF_r  <= 16'h0000;
			trigS_r  <= 3'h0;
			trigF_r  <= 1'b0;
		end else begin
			tempS1_r <= tempSense;
			tempS2_r <= tempS1_r;
			tempS3_r <= tempS2_r;
			if (tempS2_r == tempS3_r) begin
				tempF_r <= tempS3_r;
			end
			trigS_r <= {trigS_r[1:0], extTrigger};
			if (trigS_r[1] == trigS_r[2]) begin
				trigF_r <= trigS_r[2];
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			trigPrev_r <= 1'b0;
		end else begin
			trigPrev_r <= trigF_r;
		end
	end
	assign trigRise = trigF_r && !trigPrev_r && cmd[`CCDREG_CB_TRIGEN];

	// ====================================================================
	// rate enables: timer step and temperature refresh
	always_ff @(posedge ref_clk) begin
		if (!rstn || stepCnt_r == TMR_STEP_CYC - 1) begin
			stepCnt_r <= 32'h0000_0000;
		end else begin
			stepCnt_r <= stepCnt_r + 32'h0000_0001;
		end
	end
	assign tmrStep = (stepCnt_r == TMR_STEP_CYC - 1);

	always_ff @(posedge ref_clk) begin
		if (!rstn || tempCnt_r == TEMP_UPD_CYC - 1) begin
			tempCnt_r <= 32'h0000_0000;
		end else begin
			tempCnt_r <= tempCnt_r + 32'h0000_0001;
		end
	end
	assign tempUpd = (tempCnt_r == TEMP_UPD_CYC - 1);

	// ====================================================================
	// exposure timer; loads only while load-enable is set, frozen meanwhile
	always_ff @(posedge ref_clk) begin
		if (seqRst) begin
			timer_r <= 20'h00000;
		end else if (cmd[`CCDREG_CB_TMRLOAD]) begin
			if (regWr && selIs(regSel, `CCDREG_R_TIMER)) begin
				timer_r[15:0] <= regWrData;
			end else if (regWr && selIs(regSel, `CCDREG_R_VBIN)) begin
				timer_r[19:16] <= regWrData[3:0];
			end
		end else if (state_r == ccdreg_pkg::ST_EXPOSE && tmrStep && timer_r != 20'h00000) begin
			timer_r <= timer_r - 20'h00001;
		end
	end

	// ====================================================================
	// sequencer: flush, expose, offset skip, line digitise, hold
	always_ff @(posedge ref_clk) begin
		if (seqRst) begin
			state_r  <= ccdreg_pkg::ST_IDLE;
			colPh_r  <= ccdreg_pkg::COL_BEFORE;
			cnt_r    <= 12'h000;
			binCnt_r <= 4'h0;
		end else begin
			case (state_r)
			ccdreg_pkg::ST_IDLE, ccdreg_pkg::ST_FLUSH, ccdreg_pkg::ST_HOLD: begin
				if (cmdFell(cmdPrev_r, cmd, `CCDREG_CB_STARTTMR) || trigRise) begin
					state_r <= ccdreg_pkg::ST_EXPOSE;
				end else if (cmdFell(cmdPrev_r, cmd, `CCDREG_CB_STARTFL)) begin
					state_r <= ccdreg_pkg::ST_FLUSH;
				end else if (state_r == ccdreg_pkg::ST_FLUSH
					&& cmdFell(cmdPrev_r, cmd, `CCDREG_CB_STOPFLUSH)) begin
					state_r <= ccdreg_pkg::ST_IDLE;
				end else if (state_r == ccdreg_pkg::ST_HOLD
					&& cmdFell(cmdPrev_r, cmd, `CCDREG_CB_NEXTLINE)) begin
					state_r <= ccdreg_pkg::ST_ROWS;
					cnt_r   <= 12'h000;
				end
			end
			ccdreg_pkg::ST_EXPOSE: begin
				if (timer_r == 20'h00000 && !cmd[`CCDREG_CB_TMRLOAD]) begin
					state_r <= ccdreg_pkg::ST_SKIP;
					cnt_r   <= 12'h000;
				end
			end
			ccdreg_pkg::ST_SKIP: begin
				// one row shift per unbinned row, binning plays no part
				if (cnt_r >= geom.lineCount) begin
					state_r <= ccdreg_pkg::ST_ROWS;
					cnt_r   <= 12'h000;
				end else begin
					cnt_r <= cnt_r + 12'h001;
				end
			end
			ccdreg_pkg::ST_ROWS: begin
				if (cnt_r >= {4'h0, geom.vBin} - 12'h001 || geom.vBin == 8'h00) begin
					state_r  <= ccdreg_pkg::ST_COLS;
					colPh_r  <= ccdreg_pkg::COL_BEFORE;
					cnt_r    <= 12'h000;
					binCnt_r <= 4'h0;
				end else begin
					cnt_r <= cnt_r + 12'h001;
				end
			end
			ccdreg_pkg::ST_COLS: begin
				case (colPh_r)
				ccdreg_pkg::COL_BEFORE: begin
					if (cnt_r >= geom.beforeCols) begin
						colPh_r <= ccdreg_pkg::COL_PIXEL;
						cnt_r   <= 12'h000;
					end else begin
						cnt_r <= cnt_r + 12'h001;
					end
				end
				ccdreg_pkg::COL_PIXEL: begin
					if (cnt_r >= geom.pixCount) begin
						colPh_r <= ccdreg_pkg::COL_AFTER;
						cnt_r   <= 12'h000;
					end else if (binCnt_r + 4'h1 < geom.hBin) begin
						binCnt_r <= binCnt_r + 4'h1;
					end else if (fifoInReady) begin
						// a full fifo stalls the column clock, no sample is dropped
						binCnt_r <= 4'h0;
						cnt_r    <= cnt_r + 12'h001;
					end
				end
				default: begin
					if (cnt_r >= geom.afterCols) begin
						state_r <= ccdreg_pkg::ST_HOLD;
						cnt_r   <= 12'h000;
					end else begin
						cnt_r <= cnt_r + 12'h001;
					end
				end
				endcase
			end
			default: begin
				state_r <= ccdreg_pkg::ST_IDLE;
			end
			endcase
		end
	end

	assign fifoPush = state_r == ccdreg_pkg::ST_COLS && colPh_r == ccdreg_pkg::COL_PIXEL
		&& cnt_r < geom.pixCount && binCnt_r + 4'h1 >= geom.hBin;

	// ====================================================================
	// sensor drive, registered
	always_ff @(posedge ref_clk) begin
		if (seqRst) begin
			drive_r <= '0;
		end else begin
			drive_r.vClk <= state_r == ccdreg_pkg::ST_FLUSH || state_r == ccdreg_pkg::ST_ROWS
				|| (state_r == ccdreg_pkg::ST_SKIP && cnt_r < geom.lineCount);
			drive_r.hClk <= state_r == ccdreg_pkg::ST_COLS && (!fifoPush || fifoInReady)
				&& !(colPh_r == ccdreg_pkg::COL_PIXEL && cnt_r >= geom.pixCount);
			drive_r.shutter <= cmd[`CCDREG_CB_SHUTOVR]
				|| (state_r == ccdreg_pkg::ST_EXPOSE && cmd[`CCDREG_CB_SHUTEN]);
		end
	end
	assign ccdDrive = drive_r;

	ccdreg_fifo #(
		.WIDTH(`CCDREG_FIFO_W),
		.DEPTH(`CCDREG_FIFO_D)
	) u_fifo (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.flush   (softRst),
		.inData  (adcSample),
		.inValid (fifoPush),
		.inReady (fifoInReady),
		.outData (fifoOut),
		.outValid(fifoOutValid),
		.outReady(fifoPop)
	);
	assign fifoPop = regRd && selIs(regSel, `CCDREG_R_PIXDATA);

	// ====================================================================
	// cooler regulation and temperature sampling
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			temp_r <= 16'h0000;
		end else if (tempUpd) begin
			temp_r <= tempF_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (seqRst || !cmd[`CCDREG_CB_COOLEN]) begin
			level_r <= 8'h00;
		end else if (tempUpd) begin
			if (cmd[`CCDREG_CB_COOLDOWN]) begin
				if (level_r != 8'h00) begin
					level_r <= level_r - 8'h01; // controlled ramp to ambient
				end
			end else if (temp_r[11:0] > regs_r[4][11:0] && level_r != `CCDREG_LEVEL_MAX) begin
				level_r <= level_r + 8'h01;
			end else if (temp_r[11:0] < regs_r[4][11:0] && level_r != 8'h00) begin
				level_r <= level_r - 8'h01;
			end
		end
	end
	assign coolerDrive = level_r;

	// flag follows the live band, so it may drop after first reaching it
	assign atTemp = cmd[`CCDREG_CB_COOLEN] && !cmd[`CCDREG_CB_COOLDOWN]
		&& temp_r[11:0] + `CCDREG_TEMP_BAND >= regs_r[4][11:0]
		&& temp_r[11:0] <= regs_r[4][11:0] + `CCDREG_TEMP_BAND;
	assign maxLim = cmd[`CCDREG_CB_COOLEN] && !cmd[`CCDREG_CB_COOLDOWN] && !atTemp
		&& level_r == `CCDREG_LEVEL_MAX && temp_r[11:0] > regs_r[4][11:0];
	assign minLim = cmd[`CCDREG_CB_COOLEN] && !cmd[`CCDREG_CB_COOLDOWN] && !atTemp
		&& level_r == 8'h00 && temp_r[11:0] < regs_r[4][11:0];
	assign rampDone = cmd[`CCDREG_CB_COOLEN] && cmd[`CCDREG_CB_COOLDOWN] && level_r == 8'h00;

	always_comb begin
		status = 16'h0000;
		status[`CCDREG_SB_LINERDY]  = state_r == ccdreg_pkg::ST_HOLD;
		status[`CCDREG_SB_EXPOSING] = state_r == ccdreg_pkg::ST_EXPOSE;
		status[`CCDREG_SB_FLUSHING] = state_r == ccdreg_pkg::ST_FLUSH;
		status[`CCDREG_SB_DATAAVL]  = fifoOutValid;
		status[`CCDREG_SB_MINLIM]   = minLim;
		status[`CCDREG_SB_MAXLIM]   = maxLim;
		status[`CCDREG_SB_RAMPDONE] = rampDone;
		status[`CCDREG_SB_ATTEMP]   = atTemp;
	end

	// ====================================================================
	// read port, one cycle after the request
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			regRdData <= 16'h0000;
		end else if (regRd) begin
			case (regSel)
			`CCDREG_R_TIMER:   regRdData <= timer_r[15:0];
			`CCDREG_R_VBIN:    regRdData <= {regs_r[2][15:4], timer_r[19:16]};
			`CCDREG_R_PIXDATA: regRdData <= fifoOutValid ? fifoOut : 16'h0000;
			`CCDREG_R_TEMP:    regRdData <= temp_r;
			`CCDREG_R_STATUS:  regRdData <= status;
			`CCDREG_R_MIRROR:  regRdData <= cmd;
			`CCDREG_R_CMD, `CCDREG_R_AIC, `CCDREG_R_SETPOINT, `CCDREG_R_PIXCNT, `CCDREG_R_LINECNT,
			`CCDREG_R_BIC: begin
				regRdData <= regs_r[3'(regSel - 4'h1)];
			end
			default: begin
				regRdData <= 16'h0000;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== tb/ccdreg_assertions.sv ====
// port checker for the camera register bank
`timescale 1ns/10ps
`default_nettype none
module ccdreg_checker (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  regSel,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [15:0] regWrData,
	input  wire logic [15:0] regRdData,
	input  wire logic [7:0]  coolerDrive,
	input  wire logic [3:0]  digPort
);
	logic [15:0] shadow_r [1:8];
	logic [15:0] rdExp_r;
	logic        rampExp_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// ========
	// shadow copies; writes above register 8 never land
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			for (int i = 1; i <= 8; i++) begin
				shadow_r[i] <= 16'h0000;
			end
		end else if (regWr && regSel >= 4'h1 && regSel <= 4'h8) begin
			shadow_r[regSel] <= regWrData;
		end
	end

	// expected answer taken at the read edge, before any write lands
	always_ff @(posedge ref_clk) begin
		if (regSel == 4'hC) begin
			rdExp_r <= shadow_r[1];
		end else if (regSel >= 4'h1 && regSel <= 4'h8) begin
			rdExp_r <= shadow_r[regSel];
		end else begin
			rdExp_r <= 16'h0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		rampExp_r <= shadow_r[1][15] && shadow_r[1][8] && coolerDrive == 8'h00;
	end

	// ========
	// assertions
	chk_unmapped_read: assert property (regRd && (regSel == 4'h0 || regSel > 4'hC) |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	chk_rw_readback: assert property (regRd && regSel inside {4'h1, [4'h4:4'h8]} |=> regRdData == rdExp_r)
		else $error("writable register read back wrong");
	chk_read_holds: assert property (!$past(regRd) |-> $stable(regRdData))
		else $error("read data moved without a read");
	chk_cmd_mirror: assert property (regRd && regSel == 4'hC |=> regRdData == rdExp_r)
		else $error("command mirror differs from last command");
	chk_port_field: assert property (regWr && regSel == 4'h5 |=> digPort == shadow_r[5][15:12])
		else $error("digital port not taken from setpoint register");
	chk_ro_write: assert property (regWr && regSel >= 4'h9 |=> $stable(digPort))
		else $error("read-only write changed state");
	chk_cooler_off: assert property (!shadow_r[1][15] [*3] |-> coolerDrive == 8'h00)
		else $error("cooler driven while disabled");
	chk_ramp_flag: assert property (regRd && regSel == 4'hB |=> regRdData[6] == rampExp_r)
		else $error("ramp complete flag wrong");
	chk_limit_excl: assert property (regRd && regSel == 4'hB |=> !(regRdData[4] && regRdData[5]))
		else $error("both cooler limits reported");
endmodule
`default_nettype wire

// ==== tb/ccdreg_host_model.sv ====
// host driver model: polled register reads and writes
`timescale 1ns/10ps
`default_nettype none
module ccdreg_host (
	input  wire logic        ref_clk,
	output logic      [3:0]  regSel,
	output logic             regWr,
	output logic             regRd,
	output logic      [15:0] regWrData,
	input  wire logic [15:0] regRdData
);
	initial begin
		regSel = 4'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		regWrData = 16'hA5A5;
	end

	// ========
	// one-cycle strobe; data line shows the inverse once released
	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		@(negedge ref_clk);
		regSel = s;
		regWrData = d;
		regWr = 1'b1;
		@(negedge ref_clk);
		regWr = 1'b0;
		regWrData = ~d;
	endtask

	// no interrupt exists, so every state change is learned by polling reads
	task automatic rd(input logic [3:0] s, output logic [15:0] d);
		@(negedge ref_clk);
		regSel = s;
		regRd = 1'b1;
		@(negedge ref_clk);
		regRd = 1'b0;
		@(negedge ref_clk);
		d = regRdData;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the camera register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic                      ref_clk;
	logic                      rstn;
	logic [3:0]                regSel;
	logic                      regWr;
	logic                      regRd;
	logic [15:0]               regWrData;
	logic [15:0]               regRdData;
	ccdreg_pkg::ccdreg_drive_t drive;
	logic [15:0]               adcSample;
	logic                      extTrigger;
	logic [15:0]               tempSense;
	logic [7:0]                coolerDrive;
	logic [3:0]                digPort;
	logic [15:0]               v;
	logic [15:0]               d;
	logic [15:0]               pix;
	logic [15:0]               exp [1:8];
	logic [31:0]               seed;
	int                        errCount;
	int                        comparisons;
	int                        vCnt;
	int                        hCnt;

	ccdreg_top #(.TMR_STEP_CYC(10), .TEMP_UPD_CYC(20)) dut (.ref_clk(ref_clk), .rstn(rstn), .regSel(regSel),
		.regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .ccdDrive(drive),
		.adcSample(adcSample), .extTrigger(extTrigger), .tempSense(tempSense), .coolerDrive(coolerDrive),
		.digPort(digPort));
	ccdreg_host host (.ref_clk(ref_clk), .regSel(regSel), .regWr(regWr), .regRd(regRd),
		.regWrData(regWrData), .regRdData(regRdData));

	// ========
	// helpers
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// line counter gets whole binned groups, still counted in rows
	function automatic logic [15:0] wholeRows(input int off, input int vb);
		return 16'(off - off % vb);
	endfunction

	task automatic check(input string n, input logic [15:0] got, input logic [15:0] e);
		comparisons++;
		if (got !== e) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", n, e, got);
		end
	endtask

	// bounded poll, slow on purpose so the fifo side sees a stalling host
	task automatic pollStatus(input int b, input logic want);
		for (int k = 0; k < 300; k++) begin
			host.rd(4'hB, v);
			if (v[b] === want) return;
		end
		check("status poll", {15'h0000, v[b]}, {15'h0000, want});
	endtask

	task automatic finishTest;
		if (errCount == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (drive.vClk === 1'b1) vCnt++;
		if (drive.hClk === 1'b1) hCnt++;
	end

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		errCount++;
		finishTest;
	end

	// ========
	// main sequence
	initial begin
		rstn = 1'b0;
		tempSense = 16'h0100;
		adcSample = 16'h0000;
		extTrigger = 1'b0;
		seed = 32'h380A891A;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		rstn = 1'b1;
		for (int i = 0; i < 16; i++) begin
			if (i < 10 || i > 11) begin
				host.rd(i[3:0], v);
				check("reset or unmapped", v, 16'h0000);
			end
		end
		// random contents; command limited to bits that only store
		for (int n = 0; n < 6; n++) begin
			for (int i = 1; i < 16; i++) begin
				seed = lfsrNext(seed);
				d = (i == 1) ? (seed[15:0] & 16'h6211) : seed[15:0];
				if (i != 2 && i != 3) host.wr(i[3:0], d);
				if (i != 2 && i != 3 && i <= 8) exp[i] = d;
			end
			for (int i = 1; i <= 12; i++) begin
				if (i == 1 || (i >= 4 && i <= 8) || i == 12) begin
					host.rd(i[3:0], v);
					check("register readback", v, exp[i == 12 ? 1 : i]);
				end
			end
			check("digital port", {12'h000, digPort}, {12'h000, exp[5][15:12]});
		end
		// timer load, geometry, first line with row offset 7 binned by 2
		host.wr(4'h5, 16'h0100);
		host.wr(4'h1, 16'h0400);
		host.wr(4'h2, 16'h0005);
		host.wr(4'h3, 16'h0020);
		host.rd(4'h2, v);
		check("timer low", v, 16'h0005);
		host.rd(4'h3, v);
		check("timer high and binning", v, 16'h0020);
		host.wr(4'h6, 16'h2004);
		host.wr(4'h7, wholeRows(7, 2));
		host.wr(4'h8, 16'h0002);
		host.wr(4'h4, 16'h0001);
		host.wr(4'h1, 16'h0000);
		seed = lfsrNext(seed);
		pix = seed[15:0] | 16'h0001;
		adcSample = pix;
		vCnt = 0;
		hCnt = 0;
		host.wr(4'h1, 16'h0002);
		host.wr(4'h1, 16'h0000);
		pollStatus(0, 1'b1);
		check("rows shifted", 16'(vCnt), 16'(6 + 2));
		check("columns shifted", 16'(hCnt), 16'(3 + 4 * 2 + 2));
		for (int k = 0; k < 5; k++) begin
			host.rd(4'h9, v);
			check("pixel data", v, k < 4 ? pix : 16'h0000);
		end
		// leftover row skipped by one next-line; 40 samples exceed the 32-deep fifo and stall the column clock
		host.wr(4'h3, 16'h0010);
		host.wr(4'h6, 16'h1028);
		seed = lfsrNext(seed);
		pix = seed[15:0] | 16'h0001;
		adcSample = pix;
		vCnt = 0;
		hCnt = 0;
		host.wr(4'h1, 16'h0800);
		host.wr(4'h1, 16'h0000);
		repeat (150) @(negedge ref_clk);
		check("stalled while full", 16'(hCnt < 45), 16'h0001);
		for (int k = 0; k < 40; k++) begin
			host.rd(4'h9, v);
			check("pixel drain", v, pix);
		end
		pollStatus(0, 1'b1);
		check("leftover rows", 16'(vCnt), 16'(7 % 2));
		check("full line columns", 16'(hCnt), 16'(3 + 40 + 2));
		host.rd(4'h9, v);
		check("drained fifo", v, 16'h0000);
		// shutter override, flush stopped by command, then flush cut by soft reset
		host.wr(4'h1, 16'h0004);
		@(negedge ref_clk);
		check("shutter override", {15'h0000, drive.shutter}, 16'h0001);
		for (int n = 0; n < 2; n++) begin
			host.wr(4'h1, 16'h1000);
			host.wr(4'h1, 16'h0000);
			pollStatus(2, 1'b1);
			host.wr(4'h1, n == 0 ? 16'h0040 : 16'h0008);
			host.wr(4'h1, 16'h0000);
			host.rd(4'hB, v);
			check("flush ended", v, 16'h0000);
		end
		host.rd(4'h6, v);
		check("registers kept", v, 16'h1028);
		// cooler: at setpoint, then warmer, then controlled shutdown
		host.wr(4'h1, 16'h8000);
		pollStatus(7, 1'b1);
		host.rd(4'hA, v);
		check("temperature reading", v, tempSense);
		@(negedge ref_clk);
		tempSense = 16'h0180;
		pollStatus(7, 1'b0);
		repeat (100) @(negedge ref_clk);
		check("cooler drive", 16'(coolerDrive > 8'h00), 16'h0001);
		host.wr(4'h1, 16'h8100);
		pollStatus(6, 1'b1);
		host.rd(4'hC, v);
		check("mirror cooler bits", v, 16'h8100);
		finishTest;
	end
endmodule

bind ccdreg_top ccdreg_checker chk (.ref_clk(ref_clk), .rstn(rstn), .regSel(regSel), .regWr(regWr),
	.regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .coolerDrive(coolerDrive), .digPort(digPort));
`default_nettype wire
